// ===== pkg/spp_pkg.sv
// Shared constants, types and helpers for the serial port with pin control.
package spp_pkg;
   // Register indices; the byte address of each is four times its index.
   localparam logic [7:0] IDX_CR1 = 8'hd0;
   localparam logic [7:0] IDX_CR2 = 8'hd1;
   localparam logic [7:0] IDX_BR  = 8'hd2;
   localparam logic [7:0] IDX_SR  = 8'hd3;
   localparam logic [7:0] IDX_DR  = 8'hd5;
   localparam logic [7:0] IDX_PD  = 8'hd6;
   localparam logic [7:0] IDX_DDR = 8'hd7;
   // Control register one fields.
   localparam int CR1_IRQ_EN = 7;
   localparam int CR1_SYS_EN = 6;
   localparam int CR1_WOM    = 5;
   localparam int CR1_MASTER_SELECT   = 4;
   localparam int CR1_CLOCK_POLARITY   = 3;
   localparam int CR1_CLOCK_PHASE   = 2;
   localparam int CR1_SELECT_OUTPUT_ENABLE   = 1;
   localparam int CR1_LSB_FIRST_SELECT   = 0;
   // Control register two fields.
   localparam int CR2_SWAI   = 1;
   localparam int CR2_PINCFG = 0;
   // Status register fields.
   localparam int SR_DONE = 7;
   localparam int SR_WRITE_COLLISION_FLAG = 6;
   localparam int SR_MODE_FAULT_FLAG = 4;
   // Pin positions of the serial function in the port.
   localparam int PIN_MISO = 4;
   localparam int PIN_MOSI = 5;
   localparam int PIN_SCK  = 6;
   localparam int PIN_SS   = 7;
   // Reset values.
   localparam logic [7:0] CR1_RST = 8'h00;
   localparam logic [7:0] CR2_RST = 8'h00;
   localparam logic [2:0] BR_RST  = 3'h0;
   localparam logic [7:0] PD_RST  = 8'h00;
   localparam logic [7:0] DDR_RST = 8'h00;
   // Sixteen clock edges make one byte; this is the index of the last.
   localparam logic [3:0] LAST_EDGE = 4'hf;

   typedef enum logic [0:0] {
      SPP_IDLE = 1'b0,
      SPP_XFER = 1'b1
   } spp_state_t;

   // Shifts one received bit into the byte in the selected order.
   function automatic logic [7:0] spp_shift_in(input logic [7:0] sr,
                                               input logic       b,
                                               input logic       lsb_first_select);
      spp_shift_in = lsb_first_select ? {b, sr[7:1]} : {sr[6:0], b};
   endfunction : spp_shift_in

   // Picks the bit that goes out next.
   function automatic logic spp_out_bit(input logic [7:0] sr,
                                        input logic       lsb_first_select);
      spp_out_bit = lsb_first_select ? sr[0] : sr[7];
   endfunction : spp_out_bit
endpackage : spp_pkg

// ===== design/spp_sync.sv
// Two-stage synchroniser for the port pin inputs.
`timescale 1ns/1ps
module spp_sync #(
   parameter int W = 8
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         reset,
   // Data.
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : spp_sync

// ===== design/spp_divider.sv
// Half-period tick generator for the master serial clock.
`timescale 1ns/1ps
module spp_divider (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       reset,
   // Control.
   input  wire logic       run,
   input  wire logic [2:0] rate,
   // Tick, one cycle wide, every 2**rate cycles.
   output logic            tick
);
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   wire  [6:0] limit = 7'((8'h01 << rate) - 8'h01);

   // Held at zero while idle so the divider draws no switching power.
   assign tick  = run && (cnt_q == limit);
   assign cnt_d = (!run || tick) ? 7'h00 : 7'(cnt_q + 7'h01);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : spp_divider

// ===== design/spp_top.sv
// Serial peripheral port with shared pin control and Avalon-MM registers.
//
// Notes on behaviour
// - Select output low during transfer, high idle.
// - Pin seven role from direction and select enable.
// - Bidirectional mode uses one data pin.
// - Interrupt on done or fault when enabled.
// - Disable resets logic; enable claims pins 4-7 except the idle data pin in bidirectional mode and pin 7 as master GPIO.
// - Enable reads zero while fault flag set.
// - Wired-OR mode makes pins 4-7 open-drain.
// - Master clock idles at polarity level.
// - Bit order selectable; register keeps MSB bit7.
// - Wait mode may halt serial clock.
// - Pin config bit and master pick layout.
// - Data and clock outputs need direction bits.
// - Rate field divides clock by 2..256.
// - Done flag after eighth clock; sequence clears.
// - Busy write blocked, sets collision flag.
// - Master select input low sets fault flag.
// - Reads double-buffered, writes load shifter.
// - Eight shifts exchange master and slave bytes.
// - Port reads pin or driver; writes latch.
// - Direction resets to zero, bit selects output.
// - Serial inputs forced; outputs need direction bit.
// - Mode fault clears direction bits 5-7.
`timescale 1ns/1ps
module spp_top
   import spp_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        reset,
   // Avalon-MM slave.
   input  wire logic [9:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Port pins.
   input  wire logic [7:0]  pin_in,
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe,
   // System.
   input  wire logic        cpu_wait,
   output logic             serial_irq
);
   // Registers.
   logic [7:0]  cr1_q;
   logic [7:0]  cr2_q;
   logic [2:0]  br_q;
   logic [7:0]  pd_q;
   logic [7:0]  ddr_q;
   logic        transfer_done_flag_q;
   logic        write_collision_flag_q;
   logic        mode_fault_flag_q;
   logic        arm_transfer_done_flag_q;
   logic        arm_write_collision_flag_q;
   logic        arm_mode_fault_flag_q;
   spp_state_t  state_q;
   logic [3:0]  edge_q;
   logic        sck_ph_q;
   logic        sck_prev_q;
   logic        rx_q;
   logic [7:0]  shreg_q;
   logic [7:0]  rxbuf_q;
   logic        ack_q;
   logic [31:0] readdata_q;

   // Bus decode.
   wire [7:0] idx    = address[9:2];
   wire       req    = read | write;
   wire       acc    = req & ack_q;
   wire       wr_b0  = acc & write & byteenable[0];
   wire [7:0] wdata  = writedata[7:0];
   wire       cr1_wr = wr_b0 & (idx == IDX_CR1);
   wire       cr2_wr = wr_b0 & (idx == IDX_CR2);
   wire       br_wr  = wr_b0 & (idx == IDX_BR);
   wire       pd_wr  = wr_b0 & (idx == IDX_PD);
   wire       ddr_wr = wr_b0 & (idx == IDX_DDR);
   wire       dr_wr  = wr_b0 & (idx == IDX_DR);
   wire       dr_acc = acc & (idx == IDX_DR);
   wire       sr_rd  = acc & read & (idx == IDX_SR);

   // Control fields.
   wire en     = cr1_q[CR1_SYS_EN] & ~mode_fault_flag_q;
   wire master = cr1_q[CR1_MASTER_SELECT];
   wire clock_polarity   = cr1_q[CR1_CLOCK_POLARITY];
   wire clock_phase   = cr1_q[CR1_CLOCK_PHASE];
   wire lsb_first_select   = cr1_q[CR1_LSB_FIRST_SELECT];
   wire wom    = cr1_q[CR1_WOM];
   wire select_output_enable   = cr1_q[CR1_SELECT_OUTPUT_ENABLE];
   wire bidir  = cr2_q[CR2_PINCFG];

   // Pin inputs cross into the clock domain first.
   logic [7:0] ps;
   spp_sync #(.W(8)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     (pin_in),
      .q     (ps)
   );

   wire ss_in  = ps[PIN_SS];
   wire sck_in = ps[PIN_SCK];
   // In bidirectional mode the one data pin carries both directions.
   wire din = master ? (bidir ? ps[PIN_MOSI] : ps[PIN_MISO])
                     : (bidir ? ps[PIN_MISO] : ps[PIN_MOSI]);

   // Edge engine shared by master and slave.
   wire slave_sel  = en & ~master & ~ss_in;
   wire slave_edge = slave_sel & (sck_in ^ sck_prev_q);
   wire hold       = cr2_q[CR2_SWAI] & cpu_wait;
   wire run        = en & master & (state_q == SPP_XFER) & ~hold;
   logic tick;

   spp_divider u_div (
      .clk   (clk),
      .reset (reset),
      .run   (run),
      .rate  (br_q),
      .tick  (tick)
   );

   wire edge_ev   = master ? tick : slave_edge;
   wire leading   = ~edge_q[0];
   // With phase set the first leading edge only launches the first bit.
   wire sample_ev = edge_ev & (leading ^ clock_phase);
   wire shift_ev  = edge_ev & ~(leading ^ clock_phase) & (edge_q != 4'h0);
   wire last_ev   = edge_ev & (edge_q == LAST_EDGE);
   wire [7:0] fin = spp_shift_in(shreg_q, clock_phase ? din : rx_q, lsb_first_select);
   wire dout      = spp_out_bit(shreg_q, lsb_first_select);
   wire busy      = (state_q == SPP_XFER) | (slave_sel & (edge_q != 4'h0));
   wire wr_ok     = dr_wr & ~busy;
   wire start     = wr_ok & en & master;

   // Flags; a set in the same cycle as its clear wins.
   wire mode_fault_flag_set = cr1_q[CR1_SYS_EN] & master & ~ddr_q[PIN_SS] & ~ss_in;
   wire transfer_done_flag_d   = last_ev | (transfer_done_flag_q & ~(dr_acc & arm_transfer_done_flag_q));
   wire write_collision_flag_d   = (dr_wr & busy) | (write_collision_flag_q & ~(dr_acc & arm_write_collision_flag_q));
   wire mode_fault_flag_d   = mode_fault_flag_set | (mode_fault_flag_q & ~(cr1_wr & arm_mode_fault_flag_q));

   // Pin ownership and drive.
   logic [7:0] own;
   logic [7:0] sdrv;
   logic [7:0] sval;
   assign own[3:0]  = 4'h0;
   assign sdrv[3:0] = 4'h0;
   assign sval[3:0] = 4'h0;
   assign own[PIN_MISO]  = en & ~(master & bidir);
   assign sdrv[PIN_MISO] = ~master & ddr_q[PIN_MISO] & ~ss_in;
   assign sval[PIN_MISO] = dout;
   assign own[PIN_MOSI]  = en & (master | ~bidir);
   assign sdrv[PIN_MOSI] = master & ddr_q[PIN_MOSI];
   assign sval[PIN_MOSI] = dout;
   assign own[PIN_SCK]   = en;
   assign sdrv[PIN_SCK]  = master & ddr_q[PIN_SCK];
   assign sval[PIN_SCK]  = clock_polarity ^ sck_ph_q;
   assign own[PIN_SS]    = en & ~(master & ddr_q[PIN_SS] & ~select_output_enable);
   assign sdrv[PIN_SS]   = master & ddr_q[PIN_SS] & select_output_enable;
   assign sval[PIN_SS]   = (state_q != SPP_XFER);

   wire [7:0] drv = (own & sdrv) | (~own & ddr_q);
   wire [7:0] val = (own & sval) | (~own & pd_q);
   // Open drain only ever pulls low, so a one releases the pin.
   wire [7:0] od  = {{4{wom}} & val[7:4], 4'h0};
   wire [7:0] oe_d = drv & ~od;
   wire [7:0] pd_rd = (drv & val) | (~drv & ps);
   wire [7:0] cr1_rd = {cr1_q[7], cr1_q[6] & ~mode_fault_flag_q, cr1_q[5:0]};
   wire [7:0] sr_rd_v = {transfer_done_flag_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 4'h0};

   wire [7:0] rd_mux =
      (idx == IDX_CR1) ? cr1_rd :
      (idx == IDX_CR2) ? cr2_q :
      (idx == IDX_BR)  ? {5'h00, br_q} :
      (idx == IDX_SR)  ? sr_rd_v :
      (idx == IDX_DR)  ? rxbuf_q :
      (idx == IDX_PD)  ? pd_rd :
      (idx == IDX_DDR) ? ddr_q : 8'h00;

   // Every access waits exactly one cycle so read data can be registered.
   assign waitrequest = req & ~ack_q;
   assign readdata    = readdata_q;
   assign serial_irq  = cr1_q[CR1_IRQ_EN] & (transfer_done_flag_q | mode_fault_flag_q);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_q      <= 1'b0;
         readdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q) begin
            readdata_q <= {24'h00_0000, rd_mux};
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cr1_q <= CR1_RST;
         cr2_q <= CR2_RST;
         br_q  <= BR_RST;
         pd_q  <= PD_RST;
      end else begin
         if (cr1_wr) cr1_q <= wdata;
         if (cr2_wr) cr2_q <= wdata;
         if (br_wr)  br_q  <= wdata[2:0];
         if (pd_wr)  pd_q  <= wdata;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ddr_q <= DDR_RST;
      end else if (mode_fault_flag_set) begin
         ddr_q <= {3'h0, (ddr_wr ? wdata[4:0] : ddr_q[4:0])};
      end else if (ddr_wr) begin
         ddr_q <= wdata;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         transfer_done_flag_q     <= 1'b0;
         write_collision_flag_q     <= 1'b0;
         mode_fault_flag_q     <= 1'b0;
         arm_transfer_done_flag_q <= 1'b0;
         arm_write_collision_flag_q <= 1'b0;
         arm_mode_fault_flag_q <= 1'b0;
      end else begin
         transfer_done_flag_q <= transfer_done_flag_d;
         write_collision_flag_q <= write_collision_flag_d;
         mode_fault_flag_q <= mode_fault_flag_d;
         if (sr_rd) begin
            arm_transfer_done_flag_q <= readdata_q[SR_DONE];
            arm_write_collision_flag_q <= readdata_q[SR_WRITE_COLLISION_FLAG];
            arm_mode_fault_flag_q <= readdata_q[SR_MODE_FAULT_FLAG];
         end else begin
            if (dr_acc) arm_transfer_done_flag_q <= 1'b0;
            if (dr_acc) arm_write_collision_flag_q <= 1'b0;
            if (cr1_wr) arm_mode_fault_flag_q <= 1'b0;
         end
      end
   end

   // Transfer sequencing; disabling returns everything to idle.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q    <= SPP_IDLE;
         edge_q     <= 4'h0;
         sck_ph_q   <= 1'b0;
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_in;
         if (!en || (!master && !slave_sel)) begin
            state_q  <= SPP_IDLE;
            edge_q   <= 4'h0;
            sck_ph_q <= 1'b0;
         end else if (start) begin
            state_q <= SPP_XFER;
            edge_q  <= 4'h0;
         end else if (edge_ev) begin
            edge_q <= 4'(edge_q + 4'h1);
            if (master) sck_ph_q <= ~sck_ph_q;
            if (last_ev) state_q <= SPP_IDLE;
         end
      end
   end

   // The data path keeps its contents through reset.
   always_ff @(posedge clk) begin
      if (wr_ok) begin
         shreg_q <= wdata;
      end else if (last_ev) begin
         shreg_q <= fin;
      end else if (shift_ev) begin
         shreg_q <= spp_shift_in(shreg_q, rx_q, lsb_first_select);
      end
      if (sample_ev) rx_q <= din;
      if (last_ev) rxbuf_q <= fin;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_out <= 8'h00;
         pin_oe  <= 8'h00;
      end else begin
         pin_out <= val;
         pin_oe  <= oe_d;
      end
   end

   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   wire ss_out_mode = en & master & ddr_q[PIN_SS] & select_output_enable;

   property p_ss_out;
      ss_out_mode |-> ##1 (pin_out[PIN_SS] == $past(state_q != SPP_XFER));
   endproperty
   a_ss_out: assert property (p_ss_out)
      else $error("select output does not follow transfer state");

   property p_irq;
      $rose(transfer_done_flag_q) && cr1_q[CR1_IRQ_EN] |-> serial_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("no interrupt on transfer done");

   property p_sck_idle;
      en && master && (state_q == SPP_IDLE) && $stable(clock_polarity)
         |=> pin_out[PIN_SCK] == $past(clock_polarity);
   endproperty
   a_sck_idle: assert property (p_sck_idle)
      else $error("serial clock not at idle level");

   property p_done;
      last_ev |=> transfer_done_flag_q && (state_q == SPP_IDLE) && (rxbuf_q == shreg_q);
   endproperty
   a_done: assert property (p_done)
      else $error("done flag or buffer wrong after last edge");

   property p_write_collision_flag;
      dr_wr && busy |=> write_collision_flag_q && (edge_q != 4'h0 || state_q == SPP_XFER
                                   || $past(last_ev));
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag)
      else $error("collision not flagged");

   property p_fault_ddr;
      mode_fault_flag_set |=> mode_fault_flag_q && (ddr_q[7:5] == 3'h0);
   endproperty
   a_fault_ddr: assert property (p_fault_ddr)
      else $error("fault did not clear direction bits");

   property p_en_reads_zero;
      mode_fault_flag_q |-> (cr1_rd[CR1_SYS_EN] == 1'b0) && !en;
   endproperty
   a_en_reads_zero: assert property (p_en_reads_zero)
      else $error("enable reads one during fault");

   property p_fast_rate;
      run && (br_q == 3'h0) |-> tick;
   endproperty
   a_fast_rate: assert property (p_fast_rate)
      else $error("divide by two not ticking each cycle");

   property p_slave_drive;
      en && !master |=> !pin_oe[PIN_MISO] || $past(ddr_q[PIN_MISO] && !ss_in);
   endproperty
   a_slave_drive: assert property (p_slave_drive)
      else $error("slave output driven without select");

   property p_open_drain;
      wom |=> !(pin_oe[PIN_MOSI] && pin_out[PIN_MOSI]);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("open drain pin driven high");

   c_master_done: cover property (master && last_ev);
   c_slave_done: cover property (!master && last_ev);
   c_fault: cover property ($rose(mode_fault_flag_q));
   c_collision: cover property ($rose(write_collision_flag_q));
endmodule : spp_top

// ===== testbench/spp_slave_model.sv
// Behavioural external serial slave that answers the port in clock phase zero.
`timescale 1ns/1ps
module spp_slave_model (
   // Link pins as seen on the wires.
   input  wire logic       sck,
   input  wire logic       select_n,
   input  wire logic       mosi,
   // Format and data chosen by the bench.
   input  wire logic       clock_polarity,
   input  wire logic       lsb_first_select,
   input  wire logic [7:0] tx_byte,
   // Returned data.
   output logic            miso,
   output logic      [7:0] rx_byte
);
   logic [7:0] shift_q;
   logic       last_q;

   initial begin
      last_q  = 1'b0;
      rx_byte = 8'h00;
   end

   // A deselected slave lets the line wander, so show the inverse of the last bit.
   assign miso = select_n ? ~last_q : (lsb_first_select ? shift_q[0] : shift_q[7]);

   always @(negedge select_n) begin
      shift_q = tx_byte;
   end

   // Leading edge samples, trailing edge shifts: the send byte moves one place per cycle, filling with zeros.
   always @(sck) begin
      if (select_n === 1'b0) begin
         if (sck !== clock_polarity) begin
            rx_byte = lsb_first_select ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
         end else begin
            last_q  = miso;
            shift_q = lsb_first_select ? {1'b0, shift_q[7:1]} : {shift_q[6:0], 1'b0};
         end
      end
   end
endmodule : spp_slave_model

// ===== testbench/spi_port_with_pin_control_test.sv
// Register-level tests of the serial port with pin control.
`timescale 1ns/1ps
module spi_port_with_pin_control_test
   import spp_pkg::*;
;
   logic        clk;
   logic        reset;
   logic [9:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out;
   logic [7:0]  pin_oe;
   logic        serial_irq;
   logic        cpu_wt;
   logic        ss_ext;
   logic [3:0]  gp_ext;
   logic        m_clock_polarity;
   logic        m_lsb_first_select;
   logic [7:0]  m_tx;
   logic [7:0]  m_rx;
   logic        miso;
   logic [7:0]  ext;
   logic [7:0]  ss_cnt;
   logic [7:0]  ss_len;
   logic [7:0]  v;
   int          errors;
   int          n_compared;

   spp_top DUT (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .cpu_wait(cpu_wt), .serial_irq(serial_irq));

   spp_slave_model slave (.sck(pin_in[PIN_SCK]), .select_n(pin_in[PIN_SS]),
      .mosi(pin_in[PIN_MOSI]), .clock_polarity(m_clock_polarity), .lsb_first_select(m_lsb_first_select), .tx_byte(m_tx),
      .miso(miso), .rx_byte(m_rx));

   // Undriven clock and MOSI pins float, modelled as the inverse of the last driven value.
   assign ext    = {ss_ext, ~pin_out[6:5], miso, gp_ext};
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

   always #12.5 clk = ~clk;

   always @(posedge clk) begin
      if (pin_in[PIN_SS] === 1'b0) begin
         ss_cnt <= ss_cnt + 8'h01;
      end else if (ss_cnt != 8'h00) begin
         ss_len <= ss_cnt;
         ss_cnt <= 8'h00;
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // The request stands until waitrequest is seen low at a rising edge; the watchdog ends a hang.
   task automatic bus_rd(input logic [7:0] idx, output logic [7:0] d);
      @(posedge clk);
      address <= {idx, 2'b00};
      read    <= 1'b1;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      d = readdata[7:0];
      read <= 1'b0;
   endtask : bus_rd

   task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      address   <= {idx, 2'b00};
      writedata <= {24'h000000, d};
      write     <= 1'b1;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask : bus_wr

   task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      bus_rd(idx, d);
      chk(what, exp, d);
   endtask : rd_chk

   // Polls status; the last read arms the flag clear for a following data access.
   task automatic wait_done();
      logic [7:0] s;
      s = 8'h00;
      while (s[SR_DONE] !== 1'b1) begin
         bus_rd(IDX_SR, s);
      end
      repeat (3) @(posedge clk);
   endtask : wait_done

   task automatic final_report();
      $display("Compared %0d values, %0d mismatches", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   initial begin
      #(25ns * 30000);
      errors++;
      final_report();
   end

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      address = 10'h000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      cpu_wt = 1'b0;
      ss_ext = 1'b1;
      gp_ext = 4'h3;
      m_clock_polarity = 1'b0;
      m_lsb_first_select = 1'b0;
      m_tx = 8'h3c;
      ss_cnt = 8'h00;
      ss_len = 8'h00;
      errors = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;

      rd_chk("ctrl1_reset", IDX_CR1, 8'h00);
      rd_chk("ctrl2_reset", IDX_CR2, 8'h00);
      rd_chk("divider_reset", IDX_BR, 8'h00);
      rd_chk("direction_reset", IDX_DDR, 8'h00);
      rd_chk("unmapped", 8'hd4, 8'h00);
      bus_wr(IDX_CR2, 8'h03);
      rd_chk("ctrl2_rw", IDX_CR2, 8'h03);
      bus_wr(IDX_CR2, 8'h00);
      $display("Test registers done");

      bus_wr(IDX_DDR, 8'h0f);
      bus_wr(IDX_PD, 8'h0a);
      repeat (3) @(posedge clk);
      chk("gpio_oe", 8'h0f, pin_oe);
      chk("gpio_out", 8'h0a, {4'h0, pin_out[3:0]});
      rd_chk("port_out_read", IDX_PD, 8'hfa);
      // Pin seven stays released here so the external slave is never selected.
      bus_wr(IDX_DDR, 8'h30);
      bus_wr(IDX_PD, 8'h2a);
      bus_wr(IDX_CR1, 8'h20);
      repeat (3) @(posedge clk);
      chk("open_drain_oe", 8'h10, pin_oe & 8'hf0);
      bus_wr(IDX_CR1, 8'h00);
      bus_wr(IDX_PD, 8'h0a);
      bus_wr(IDX_DDR, 8'h00);
      repeat (4) @(posedge clk);
      rd_chk("port_in_read", IDX_PD, 8'hf3);
      $display("Test port done");

      bus_wr(IDX_DDR, 8'he0);
      bus_wr(IDX_CR1, 8'h52);
      repeat (3) @(posedge clk);
      chk("master_oe", 8'he0, pin_oe & 8'hf0);
      chk("sck_idle_low", 8'h00, {7'h00, pin_out[PIN_SCK]});
      chk("select_idle", 8'h01, {7'h00, pin_out[PIN_SS]});
      bus_wr(IDX_DR, 8'ha5);
      wait_done();
      chk("slave_rx_msb", 8'ha5, m_rx);
      chk("span_rate0", 8'h01, {7'h00, ss_len >= 8'd16 && ss_len <= 8'd20});
      chk("irq_disabled", 8'h00, {7'h00, serial_irq});
      rd_chk("status_done", IDX_SR, 8'h80);
      bus_rd(IDX_DR, v);
      rd_chk("status_cleared", IDX_SR, 8'h00);
      $display("Test master transfer done");

      m_clock_polarity = 1'b1;
      m_lsb_first_select = 1'b1;
      m_tx = 8'hc5;
      bus_wr(IDX_BR, 8'h02);
      bus_wr(IDX_CR1, 8'hdb);
      repeat (3) @(posedge clk);
      chk("sck_idle_high", 8'h01, {7'h00, pin_out[PIN_SCK]});
      bus_wr(IDX_DR, 8'h1e);
      bus_wr(IDX_DR, 8'h77);
      wait_done();
      chk("irq_raised", 8'h01, {7'h00, serial_irq});
      chk("slave_rx_lsb", 8'h1e, m_rx);
      chk("span_rate2", 8'h01, {7'h00, ss_len >= 8'd64 && ss_len <= 8'd70});
      rd_chk("status_collision", IDX_SR, 8'hc0);
      rd_chk("master_rx", IDX_DR, 8'hc5);
      rd_chk("status_clear2", IDX_SR, 8'h00);
      chk("irq_cleared", 8'h00, {7'h00, serial_irq});
      chk("select_high", 8'h81, {pin_out[PIN_SS], 6'h00, pin_oe[PIN_SS]});
      $display("Test collision done");

      bus_wr(IDX_CR2, 8'h02);
      cpu_wt <= 1'b1;
      bus_wr(IDX_DR, 8'h5a);
      repeat (40) @(posedge clk);
      chk("wait_halts_sck", 8'h01, {7'h00, pin_out[PIN_SCK]});
      rd_chk("wait_not_done", IDX_SR, 8'h00);
      cpu_wt <= 1'b0;
      wait_done();
      chk("slave_rx_wait", 8'h5a, m_rx);
      rd_chk("master_rx_wait", IDX_DR, 8'hc5);
      bus_wr(IDX_CR2, 8'h00);
      $display("Test wait done");

      bus_wr(IDX_DDR, 8'h60);
      bus_wr(IDX_CR1, 8'hd0);
      ss_ext <= 1'b0;
      repeat (8) @(posedge clk);
      rd_chk("status_fault", IDX_SR, 8'h10);
      chk("irq_fault", 8'h01, {7'h00, serial_irq});
      rd_chk("enable_reads_zero", IDX_CR1, 8'h90);
      rd_chk("direction_forced", IDX_DDR, 8'h00);
      ss_ext <= 1'b1;
      bus_rd(IDX_SR, v);
      bus_wr(IDX_CR1, 8'h00);
      rd_chk("fault_cleared", IDX_SR, 8'h00);
      chk("irq_off", 8'h00, {7'h00, serial_irq});
      $display("Test mode fault done");
      final_report();
   end
endmodule : spi_port_with_pin_control_test
